// ===== rtl/cipp_pkg.sv
// package for charger input power-path control: constants, layouts, types
//
// Function
// - factory default input current limit is either 95 mA or 475 mA per option.
// - low option decodes 0..3 as 95..380 mA, 4..7 as 475; high option decodes 0..3 as 475..190 mA, 4..7 as 95.
// - input current limit field resets to zero for either factory option.
// - current limiter loop engaging raises the maskable input loop interrupt.
// - a status bit shows live whether the current limiter loop is active.
// - minimum input voltage loop engaging raises the same input loop interrupt.
// - a separate status bit shows live whether the input voltage loop is active.
// - two-bit input quality code tracks input; any change raises maskable interrupt.
// - after a valid source appears, wait 120 ms before powering the rail; after a fault shorter than 120 ms the input switch closes at once.
// - suspend input power delivery while the over-voltage comparator is high.
// - suspend input power delivery while the under-voltage comparator reports low input.
// - in over- or under-voltage keep charger off and battery feeding rail.
// - reduce input current while input is below the programmed voltage floor.
// - load below input limit lets leftover input power charge the battery.
// - with valid input, regulate rail to its target regardless of battery.
// - load above input limit enters supplement mode, battery adds current.
// - charging done with input present and load below input limit keeps battery disconnected from rail.
// - battery connected and no input power means battery supplies the rail.
// - minimum rail setpoint is read-only and follows the rail target.
// - quality code 11 means valid input; 00 to 11 marks becoming valid.
package cipp_pkg;

    // ****************************************************************
    // timing
    // ****************************************************************
    localparam int unsigned CIPP_CLK_KHZ       = 40000;
    localparam int unsigned CIPP_DEBOUNCE_MS   = 120;
    localparam int unsigned CIPP_DEBOUNCE_CYC  = CIPP_DEBOUNCE_MS * CIPP_CLK_KHZ;

    // ****************************************************************
    // register offsets (byte addresses)
    // ****************************************************************
    localparam logic [7:0] CIPP_OFS_CONFIG_B   = 8'h00;
    localparam logic [7:0] CIPP_OFS_RAIL_CFG   = 8'h04;
    localparam logic [7:0] CIPP_OFS_STATUS_A   = 8'h08;
    localparam logic [7:0] CIPP_OFS_STATUS_B   = 8'h0C;
    localparam logic [7:0] CIPP_OFS_IRQ_FLAGS  = 8'h10;
    localparam logic [7:0] CIPP_OFS_IRQ_MASK   = 8'h14;
    localparam logic [7:0] CIPP_OFS_RAIL_MIN   = 8'h18;

    // ****************************************************************
    // field positions
    // ****************************************************************
    localparam int CIPP_POS_ILIM_SEL   = 0;
    localparam int CIPP_POS_VFLOOR_SEL = 3;
    localparam int CIPP_POS_RAIL_SEL   = 0;
    localparam int CIPP_POS_ILIM_ACT   = 0;
    localparam int CIPP_POS_VFLOOR_ACT = 1;
    localparam int CIPP_POS_QUALITY    = 0;
    localparam int CIPP_POS_LOOP_IRQ   = 0;
    localparam int CIPP_POS_QUAL_IRQ   = 1;

    // ****************************************************************
    // reset values
    // ****************************************************************
    localparam logic [2:0] CIPP_RST_ILIM_SEL   = 3'h0;
    localparam logic [2:0] CIPP_RST_VFLOOR_SEL = 3'h0;
    localparam logic [4:0] CIPP_RST_RAIL_SEL   = 5'h00;
    localparam logic [1:0] CIPP_RST_IRQ_MASK   = 2'h3;

    // ****************************************************************
    // input quality codes and current limit steps
    // ****************************************************************
    localparam logic [1:0] CIPP_QUAL_INVALID = 2'h0;
    localparam logic [1:0] CIPP_QUAL_OVER    = 2'h2;
    localparam logic [1:0] CIPP_QUAL_VALID   = 2'h3;
    localparam logic [9:0] CIPP_ILIM_STEP_MA = 10'h05F;
    localparam logic [1:0] CIPP_RESP_OKAY    = 2'h0;
    localparam logic [1:0] CIPP_RESP_SLVERR  = 2'h2;

    typedef struct packed {
        logic [4:0] rail_target_sel;
        logic [2:0] input_voltage_floor_sel;
        logic [2:0] input_current_limit_sel;
    } cipp_cfg_t;

    typedef struct packed {
        logic       load_over_limit;
        logic       charge_done;
        logic       input_voltage_floor_active;
        logic       current_limiter_active;
        logic       under_voltage;
        logic       over_voltage;
    } cipp_sense_t;

    typedef struct packed {
        logic       supplement;
        logic       reduce_input_current;
        logic       rail_regulate;
        logic       cell_terminal_to_rail;
        logic       charger_on;
        logic       input_switch_on;
    } cipp_path_t;

endpackage

// ===== rtl/cipp_debounce.sv
// stable-level debouncer: output follows input after a full quiet period
`timescale 1ns/100ps
module cipp_debounce
    import cipp_pkg::*;
#(
    parameter int unsigned P_CYCLES = CIPP_DEBOUNCE_CYC
) (
    input  wire logic i_clk_sys, // system clock
    input  wire logic i_rst_n,   // synchronised reset
    input  wire logic i_level,   // raw level
    output logic      o_level    // debounced level
);

    localparam int CW = $clog2(P_CYCLES + 1);
    localparam logic [CW-1:0] LAST = CW'(P_CYCLES - 1);

    logic [CW-1:0] count;

    // restart the wait whenever the input disagrees anew
    always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
        if (!i_rst_n) begin
            count   <= '0;
            o_level <= 1'b0;
        end else if (i_level == o_level) begin
            count   <= '0;
        end else if (count == LAST) begin
            count   <= '0;
            o_level <= i_level;
        end else begin
            count   <= count + 1'b1;
        end
    end

endmodule // cipp_debounce

// ===== rtl/cipp_top.sv
// charger input power-path control with AXI4-Lite register access
//
// Implementation choices: the register offsets and register access over AXI4-Lite.
`timescale 1ns/100ps
module cipp_top
    import cipp_pkg::*;
#(
    parameter bit          P_HIGH_DEFAULT = 1'b0,             // 95 mA factory option; 1 selects 475 mA
    parameter int unsigned P_DEBOUNCE_CYC = CIPP_DEBOUNCE_CYC // input debounce length
) (
    input  wire logic        i_clk_sys,           // 40 MHz clock
    input  wire logic        i_rst_n,             // async reset, low active
    // axi4-lite slave
    input  wire logic [7:0]  i_s_axi_awaddr,      // write address
    input  wire logic        i_s_axi_awvalid,     // write address valid
    output logic             o_s_axi_awready,     // write address ready
    input  wire logic [31:0] i_s_axi_wdata,       // write data
    input  wire logic [3:0]  i_s_axi_wstrb,       // write strobes
    input  wire logic        i_s_axi_wvalid,      // write data valid
    output logic             o_s_axi_wready,      // write data ready
    output logic [1:0]       o_s_axi_bresp,       // write response
    output logic             o_s_axi_bvalid,      // write response valid
    input  wire logic        i_s_axi_bready,      // write response ready
    input  wire logic [7:0]  i_s_axi_araddr,      // read address
    input  wire logic        i_s_axi_arvalid,     // read address valid
    output logic             o_s_axi_arready,     // read address ready
    output logic [31:0]      o_s_axi_rdata,       // read data
    output logic [1:0]       o_s_axi_rresp,       // read response
    output logic             o_s_axi_rvalid,      // read data valid
    input  wire logic        i_s_axi_rready,      // read data ready
    // analog comparators and loop indicators
    input  wire logic        i_over_voltage,      // input above over-voltage level
    input  wire logic        i_under_voltage,     // input below under-voltage level
    input  wire logic        i_limiter_loop,      // current limiter loop regulating
    input  wire logic        i_floor_loop,        // input voltage floor loop regulating
    input  wire logic        i_load_over_limit,   // rail load above input limit
    input  wire logic        i_charge_done,       // charging finished
    // controls to the analog power path
    output logic [9:0]       o_input_limit_ma,    // decoded input current limit, mA
    output logic [2:0]       o_input_voltage_floor_sel, // floor setting to input loop
    output logic [4:0]       o_rail_target_sel,   // rail regulation target
    output logic [4:0]       o_rail_min_sel,      // minimum rail setpoint
    output logic             o_input_switch_on,   // input feeds the rail
    output logic             o_charger_on,        // charger current enabled
    output logic             o_cell_terminal_to_rail, // battery switch closed
    output logic             o_rail_regulate,     // rail regulation running
    output logic             o_reduce_input_current, // floor loop throttling
    output logic             o_supplement,        // supplement mode
    output logic [1:0]       o_input_quality_code, // input quality
    output logic             o_irq                // combined unmasked flags
);

    // ****************************************************************
    // reset release and input synchronisers
    // ****************************************************************
    logic        rst_meta_n;
    logic        rst_n;
    logic [5:0]  sense_meta;
    cipp_sense_t sense;

    always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
        if (!i_rst_n) begin
            rst_meta_n <= 1'b0;
            rst_n      <= 1'b0;
        end else begin
            rst_meta_n <= 1'b1;
            rst_n      <= rst_meta_n;
        end
    end

    always_ff @(posedge i_clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            sense_meta <= '0;
            sense      <= '0;
        end else begin
            sense_meta <= {i_load_over_limit, i_charge_done, i_floor_loop,
                           i_limiter_loop, i_under_voltage, i_over_voltage};
            sense      <= sense_meta;
        end
    end

    // ****************************************************************
    // input qualification
    // ****************************************************************
    logic       raw_valid;
    logic       input_settled;
    logic [1:0] next_quality;
    logic [1:0] quality;

    assign raw_valid = !sense.over_voltage && !sense.under_voltage;

    cipp_debounce #(
        .P_CYCLES (P_DEBOUNCE_CYC)
    ) u_debounce (
        .i_clk_sys (i_clk_sys),
        .i_rst_n   (rst_n),
        .i_level   (raw_valid),
        .o_level   (input_settled)
    );

    // debouncing input reports invalid until the wait is over
    always_comb begin
        if (sense.over_voltage) begin
            next_quality = CIPP_QUAL_OVER;
        end else if (sense.under_voltage || !input_settled) begin
            next_quality = CIPP_QUAL_INVALID;
        end else begin
            next_quality = CIPP_QUAL_VALID;
        end
    end

    always_ff @(posedge i_clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            quality <= CIPP_QUAL_INVALID;
        end else begin
            quality <= next_quality;
        end
    end

    // ****************************************************************
    // current limit decode
    // ****************************************************************
    function automatic logic [9:0] ilim_ma(input logic [2:0] sel, input bit high);
        logic [2:0] steps;
        steps = 3'h0;
        if (sel[2]) begin
            steps = high ? 3'h1 : 3'h5;
        end else if (high) begin
            steps = 3'h5 - {1'b0, sel[1:0]};
        end else begin
            steps = {1'b0, sel[1:0]} + 3'h1;
        end
        return 10'(CIPP_ILIM_STEP_MA * steps);
    endfunction

    // ****************************************************************
    // configuration registers
    // ****************************************************************
    cipp_cfg_t  cfg;
    logic [1:0] irq_mask;
    logic [1:0] irq_flags;
    logic       wr_fire;
    logic [7:0] wr_addr;
    logic [31:0] wr_data;

    assign wr_fire = i_s_axi_awvalid && i_s_axi_wvalid && !o_s_axi_bvalid;
    assign wr_addr = i_s_axi_awaddr;
    assign wr_data = i_s_axi_wdata;
    assign o_s_axi_awready = wr_fire;
    assign o_s_axi_wready  = wr_fire;

    always_ff @(posedge i_clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            cfg.input_current_limit_sel <= CIPP_RST_ILIM_SEL;
            cfg.input_voltage_floor_sel <= CIPP_RST_VFLOOR_SEL;
            cfg.rail_target_sel         <= CIPP_RST_RAIL_SEL;
        end else if (wr_fire && i_s_axi_wstrb[0]) begin
            if (wr_addr == CIPP_OFS_CONFIG_B) begin
                cfg.input_current_limit_sel <= wr_data[CIPP_POS_ILIM_SEL +: 3];
                cfg.input_voltage_floor_sel <= wr_data[CIPP_POS_VFLOOR_SEL +: 3];
            end else if (wr_addr == CIPP_OFS_RAIL_CFG) begin
                cfg.rail_target_sel <= wr_data[CIPP_POS_RAIL_SEL +: 5];
            end
        end
    end

    always_ff @(posedge i_clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            irq_mask <= CIPP_RST_IRQ_MASK;
        end else if (wr_fire && i_s_axi_wstrb[0] && wr_addr == CIPP_OFS_IRQ_MASK) begin
            irq_mask <= wr_data[1:0];
        end
    end

    // ****************************************************************
    // interrupt flags, write one to clear, set wins
    // ****************************************************************
    logic       limiter_q;
    logic       floor_q;
    logic [1:0] flag_set;
    logic [1:0] flag_clr;

    always_ff @(posedge i_clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            limiter_q <= 1'b0;
            floor_q   <= 1'b0;
        end else begin
            limiter_q <= sense.current_limiter_active;
            floor_q   <= sense.input_voltage_floor_active;
        end
    end

    always_comb begin
        flag_set = '0;
        flag_set[CIPP_POS_LOOP_IRQ] = (sense.current_limiter_active && !limiter_q)
                                   || (sense.input_voltage_floor_active && !floor_q);
        flag_set[CIPP_POS_QUAL_IRQ] = next_quality != quality;
    end

    assign flag_clr = (wr_fire && i_s_axi_wstrb[0] && wr_addr == CIPP_OFS_IRQ_FLAGS)
                    ? wr_data[1:0] : 2'h0;

    always_ff @(posedge i_clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            irq_flags <= '0;
        end else begin
            irq_flags <= (irq_flags & ~flag_clr) | flag_set;
        end
    end

    assign o_irq = |(irq_flags & ~irq_mask);

    // ****************************************************************
    // write response
    // ****************************************************************
    always_ff @(posedge i_clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            o_s_axi_bvalid <= 1'b0;
            o_s_axi_bresp  <= CIPP_RESP_OKAY;
        end else if (wr_fire) begin
            o_s_axi_bvalid <= 1'b1;
            if (wr_addr == CIPP_OFS_CONFIG_B || wr_addr == CIPP_OFS_RAIL_CFG
                || wr_addr == CIPP_OFS_IRQ_FLAGS || wr_addr == CIPP_OFS_IRQ_MASK) begin
                o_s_axi_bresp <= CIPP_RESP_OKAY;
            end else begin
                // status and rail minimum are read-only
                o_s_axi_bresp <= CIPP_RESP_SLVERR;
            end
        end else if (i_s_axi_bready) begin
            o_s_axi_bvalid <= 1'b0;
        end
    end

    // ****************************************************************
    // read channel
    // ****************************************************************
    logic [31:0] rd_word;
    logic [1:0]  rd_resp;

    always_comb begin
        rd_word = 32'h0000_0000;
        rd_resp = CIPP_RESP_OKAY;
        if (i_s_axi_araddr == CIPP_OFS_CONFIG_B) begin
            rd_word[CIPP_POS_ILIM_SEL +: 3]   = cfg.input_current_limit_sel;
            rd_word[CIPP_POS_VFLOOR_SEL +: 3] = cfg.input_voltage_floor_sel;
        end else if (i_s_axi_araddr == CIPP_OFS_RAIL_CFG) begin
            rd_word[CIPP_POS_RAIL_SEL +: 5] = cfg.rail_target_sel;
        end else if (i_s_axi_araddr == CIPP_OFS_STATUS_A) begin
            rd_word[CIPP_POS_ILIM_ACT]   = sense.current_limiter_active;
            rd_word[CIPP_POS_VFLOOR_ACT] = sense.input_voltage_floor_active;
        end else if (i_s_axi_araddr == CIPP_OFS_STATUS_B) begin
            rd_word[CIPP_POS_QUALITY +: 2] = quality;
        end else if (i_s_axi_araddr == CIPP_OFS_IRQ_FLAGS) begin
            rd_word[1:0] = irq_flags;
        end else if (i_s_axi_araddr == CIPP_OFS_IRQ_MASK) begin
            rd_word[1:0] = irq_mask;
        end else if (i_s_axi_araddr == CIPP_OFS_RAIL_MIN) begin
            rd_word[CIPP_POS_RAIL_SEL +: 5] = cfg.rail_target_sel;
        end else begin
            rd_resp = CIPP_RESP_SLVERR;
        end
    end

    assign o_s_axi_arready = !o_s_axi_rvalid;

    always_ff @(posedge i_clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            o_s_axi_rvalid <= 1'b0;
            o_s_axi_rdata  <= '0;
            o_s_axi_rresp  <= CIPP_RESP_OKAY;
        end else if (i_s_axi_arvalid && !o_s_axi_rvalid) begin
            o_s_axi_rvalid <= 1'b1;
            o_s_axi_rdata  <= rd_word;
            o_s_axi_rresp  <= rd_resp;
        end else if (i_s_axi_rready) begin
            o_s_axi_rvalid <= 1'b0;
        end
    end

    // ****************************************************************
    // power path selection
    // ****************************************************************
    cipp_path_t next_path;
    cipp_path_t path;
    logic       input_ok;

    assign input_ok = next_quality == CIPP_QUAL_VALID;

    always_comb begin
        next_path = '0;
        if (input_ok) begin
            next_path.input_switch_on      = 1'b1;
            next_path.rail_regulate        = 1'b1;
            next_path.reduce_input_current = sense.input_voltage_floor_active;
            if (sense.load_over_limit) begin
                next_path.supplement            = 1'b1;
                next_path.cell_terminal_to_rail = 1'b1;
            end else if (sense.charge_done) begin
                next_path.cell_terminal_to_rail = 1'b0;
            end else begin
                next_path.charger_on = 1'b1;
            end
        end else begin
            // suspended or absent input: battery carries the rail
            next_path.charger_on            = 1'b0;
            next_path.cell_terminal_to_rail = 1'b1;
        end
    end

    always_ff @(posedge i_clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            path <= '0;
        end else begin
            path <= next_path;
        end
    end

    always_ff @(posedge i_clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            o_input_limit_ma <= '0;
        end else begin
            o_input_limit_ma <= ilim_ma(cfg.input_current_limit_sel, P_HIGH_DEFAULT);
        end
    end

    assign o_input_switch_on         = path.input_switch_on;
    assign o_charger_on              = path.charger_on;
    assign o_cell_terminal_to_rail   = path.cell_terminal_to_rail;
    assign o_rail_regulate           = path.rail_regulate;
    assign o_reduce_input_current    = path.reduce_input_current;
    assign o_supplement              = path.supplement;
    assign o_input_quality_code      = quality;
    assign o_input_voltage_floor_sel = cfg.input_voltage_floor_sel;
    assign o_rail_target_sel         = cfg.rail_target_sel;
    assign o_rail_min_sel            = cfg.rail_target_sel;

endmodule // cipp_top

// ===== sim/cipp_source_model.sv
// far side: source and cell levels
`timescale 1ns/100ps
module cipp_source_model
    import cipp_pkg::*;
#(parameter int P_OVP_MV = 7500, P_UV_MV = 3500) (
    input  wire logic        i_clk_sys, // clock
    input  wire logic [15:0] i_mv,      // input volts, mV
    input  wire cipp_sense_t i_cond,    // loops, load, done
    output cipp_sense_t      o_sense    // comparator pins
);
    always_ff @(posedge i_clk_sys) begin
        o_sense <= i_cond;
        o_sense.over_voltage <= i_mv > P_OVP_MV;
        o_sense.under_voltage <= i_mv < P_UV_MV;
    end
endmodule // cipp_source_model

// ===== sim/cipp_top_assertions.sv
// power-path port checker
`timescale 1ns/100ps
module cipp_checker
    import cipp_pkg::*;
#(parameter int unsigned P_DEBOUNCE_CYC = 16) (
    input wire logic       i_clk_sys, // clock
    input wire logic       i_rst_n, // reset
    input wire logic       i_over_voltage, // ovp
    input wire logic       i_under_voltage, // uvlo
    input wire logic       o_s_axi_rvalid, // read
    input wire logic       i_s_axi_rready, // read
    input wire logic [9:0] o_input_limit_ma, // limit
    input wire logic [4:0] o_rail_target_sel, // target
    input wire logic [4:0] o_rail_min_sel, // min
    input wire logic       o_input_switch_on, // path
    input wire logic       o_charger_on, // path
    input wire logic       o_cell_terminal_to_rail, // path
    input wire logic       o_rail_regulate, // path
    input wire logic [1:0] o_input_quality_code // quality
);
    int unsigned good;
    logic [2:0]  up;
    always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
        if (!i_rst_n) begin
            good <= 0;
            up <= 3'h0;
        end else begin
            good <= i_under_voltage ? 0 : good + (good < P_DEBOUNCE_CYC);
            up <= (up == 3'h7) ? up : up + 3'h1;
        end
    end
    default clocking @(posedge i_clk_sys); endclocking
    default disable iff (!i_rst_n);
    property p_min; o_rail_min_sel == o_rail_target_sel; endproperty
    a_min: assert property (p_min) else $error("rail min off");
    property p_lim; up == 3'h7 |->
        o_input_limit_ma inside {10'h05F, 10'h0BE, 10'h11D, 10'h17C, 10'h1DB}; endproperty
    a_lim: assert property (p_lim) else $error("bad limit");
    property p_ovp; o_input_quality_code == CIPP_QUAL_OVER |->
        !o_input_switch_on && !o_charger_on && o_cell_terminal_to_rail; endproperty
    a_ovp: assert property (p_ovp) else $error("ovp path");
    property p_uv; (i_under_voltage && !i_over_voltage)[*5] |->
        o_input_quality_code == CIPP_QUAL_INVALID && !o_charger_on; endproperty
    a_uv: assert property (p_uv) else $error("uvlo path");
    property p_sw; o_input_switch_on |->
        o_input_quality_code == CIPP_QUAL_VALID && o_rail_regulate; endproperty
    a_sw: assert property (p_sw) else $error("switch early");
    property p_db; $rose(o_input_quality_code == CIPP_QUAL_VALID) |->
        good == P_DEBOUNCE_CYC; endproperty
    a_db: assert property (p_db) else $error("debounce short");
    property p_bat; up == 3'h7 && o_input_quality_code != CIPP_QUAL_VALID |->
        o_cell_terminal_to_rail; endproperty
    a_bat: assert property (p_bat) else $error("cell open");
    property p_rhold; o_s_axi_rvalid && !i_s_axi_rready |=> o_s_axi_rvalid; endproperty
    a_rhold: assert property (p_rhold) else $error("rvalid dropped");
    c_on: cover property (o_input_switch_on);
    c_ovp: cover property (o_input_quality_code == CIPP_QUAL_OVER);
    c_wait: cover property (o_s_axi_rvalid && !i_s_axi_rready);
endmodule // cipp_checker
bind cipp_top cipp_checker #(.P_DEBOUNCE_CYC(P_DEBOUNCE_CYC)) u_chk (.*);

// ===== sim/tb_top.sv
// bench for the power-path block
`timescale 1ns/100ps
module tb_top
    import cipp_pkg::*;
;
    localparam int unsigned DB = 16;
    logic i_clk_sys = 0, i_rst_n = 0, i_s_axi_awvalid = 0, i_s_axi_wvalid = 0;
    logic i_s_axi_bready = 1, i_s_axi_arvalid = 0, i_s_axi_rready = 0;
    logic [7:0] i_s_axi_awaddr = 0, i_s_axi_araddr = 0;
    logic [31:0] i_s_axi_wdata = 0, o_s_axi_rdata;
    logic [3:0] i_s_axi_wstrb = 4'hF;
    logic o_s_axi_awready, o_s_axi_wready, o_s_axi_bvalid, o_s_axi_arready, o_s_axi_rvalid;
    logic o_input_switch_on, o_charger_on, o_cell_terminal_to_rail, o_irq;
    logic o_rail_regulate, o_reduce_input_current, o_supplement;
    logic [1:0] o_s_axi_bresp, o_s_axi_rresp, o_input_quality_code;
    logic [9:0] o_input_limit_ma;
    logic [2:0] o_input_voltage_floor_sel;
    logic [4:0] o_rail_target_sel, o_rail_min_sel;
    logic [15:0] mv = '0;
    cipp_sense_t cond = '0, sense;
    cipp_path_t pv;
    logic [33:0] expq[$];
    int error_cnt = 0, n_checks = 0;
    assign pv = {o_supplement, o_reduce_input_current, o_rail_regulate,
                 o_cell_terminal_to_rail, o_charger_on, o_input_switch_on};
    cipp_top #(.P_HIGH_DEFAULT(1'b0), .P_DEBOUNCE_CYC(DB)) u_dut (.*,
        .i_over_voltage(sense.over_voltage), .i_under_voltage(sense.under_voltage),
        .i_limiter_loop(sense.current_limiter_active),
        .i_floor_loop(sense.input_voltage_floor_active),
        .i_load_over_limit(sense.load_over_limit), .i_charge_done(sense.charge_done));
    cipp_source_model u_src (.i_clk_sys, .i_mv(mv), .i_cond(cond), .o_sense(sense));
    initial forever #12.5 i_clk_sys = ~i_clk_sys;
    task automatic check(input logic [33:0] e, g);
        n_checks++;
        if (g !== e) begin
            error_cnt++;
            $display("[ERR] %0t exp %h got %h", $time, e, g);
        end
    endtask
    task pchk(input cipp_path_t m, v);
        check(34'(v), 34'(pv & m));
    endtask
    task cyc(input int n);
        repeat (n) @(posedge i_clk_sys);
    endtask
    task wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] r = CIPP_RESP_OKAY);
        expq.push_back({r, 32'h0});
        i_s_axi_awaddr <= a;
        i_s_axi_wdata <= d;
        {i_s_axi_awvalid, i_s_axi_wvalid} <= 2'b11;
        do cyc(1); while (!(o_s_axi_awready && o_s_axi_wready));
        {i_s_axi_awvalid, i_s_axi_wvalid} <= 2'b00;
        do cyc(1); while (!o_s_axi_bvalid);
    endtask
    task rd(input logic [7:0] a, input logic [31:0] d = 32'h0,
            input logic [1:0] r = CIPP_RESP_OKAY);
        expq.push_back({r, d});
        i_s_axi_araddr <= a;
        i_s_axi_arvalid <= 1'b1;
        do cyc(1); while (!o_s_axi_arready);
        i_s_axi_arvalid <= 1'b0;
        do cyc(1); while (!o_s_axi_rvalid);
        i_s_axi_rready <= 1'b1;
        cyc(1);
        i_s_axi_rready <= 1'b0;
    endtask
    always @(posedge i_clk_sys) begin
        if (o_s_axi_bvalid && i_s_axi_bready) check(expq.pop_front(), {o_s_axi_bresp, 32'h0});
        if (o_s_axi_rvalid && i_s_axi_rready) check(expq.pop_front(), {o_s_axi_rresp, o_s_axi_rdata});
    end
    task finish_test;
        $display("checks %0d errors %0d", n_checks, error_cnt);
        if (error_cnt == 0 && n_checks > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask
    initial begin
        #200000;
        error_cnt++;
        finish_test();
    end
    initial begin
        logic [31:0] r;
        r = $urandom(32'h2D026B7D);
        cyc(16);
        i_rst_n <= 1'b1;
        cyc(3);
        rd(CIPP_OFS_CONFIG_B);
        check(34'h05F, 34'(o_input_limit_ma));
        rd(CIPP_OFS_IRQ_MASK, 32'h3);
        rd(8'h1C, 32'h0, CIPP_RESP_SLVERR);
        wr(CIPP_OFS_STATUS_A, 32'h3, CIPP_RESP_SLVERR);
        pchk(6'h0F, 6'h04);
        for (int c = 0; c < 8; c++) begin
            r = $urandom & 32'h7;
            wr(CIPP_OFS_CONFIG_B, (r << 3) | c);
            cyc(1);
            check(34'((c < 4 ? c + 1 : 5) * CIPP_ILIM_STEP_MA), 34'(o_input_limit_ma));
            check(34'(r), 34'(o_input_voltage_floor_sel));
        end
        r = $urandom & 32'h1F;
        wr(CIPP_OFS_RAIL_CFG, r);
        wr(CIPP_OFS_RAIL_MIN, 32'h0, CIPP_RESP_SLVERR);
        rd(CIPP_OFS_RAIL_MIN, r);
        wr(CIPP_OFS_IRQ_MASK, 32'h0);
        mv <= 16'h1388;
        cyc(DB / 2);
        rd(CIPP_OFS_STATUS_B);
        cyc(DB);
        rd(CIPP_OFS_STATUS_B, 32'h3);
        pchk(6'h2B, 6'h0B);
        rd(CIPP_OFS_IRQ_FLAGS, 32'h2);
        wr(CIPP_OFS_IRQ_FLAGS, 32'h2);
        check(34'h0, 34'(o_irq));
        cond.current_limiter_active <= 1'b1;
        cyc(6);
        check(34'h1, 34'(o_irq));
        rd(CIPP_OFS_STATUS_A, 32'h1);
        wr(CIPP_OFS_IRQ_FLAGS, 32'h1);
        cond.input_voltage_floor_active <= 1'b1;
        cyc(6);
        check(34'h1, 34'(o_irq));
        rd(CIPP_OFS_STATUS_A, 32'h3);
        pchk(6'h10, 6'h10);
        cond.charge_done <= 1'b1;
        cyc(6);
        pchk(6'h04, 6'h00);
        cond.load_over_limit <= 1'b1;
        cyc(6);
        pchk(6'h20, 6'h20);
        cond <= '0;
        wr(CIPP_OFS_IRQ_FLAGS, 32'h3);
        wr(CIPP_OFS_IRQ_MASK, 32'h2);
        mv <= 16'h2328;
        cyc(6);
        check(34'h0, 34'(o_irq));
        rd(CIPP_OFS_STATUS_B, 32'h2);
        pchk(6'h07, 6'h04);
        mv <= 16'h0BB8;
        cyc(6);
        rd(CIPP_OFS_IRQ_FLAGS, 32'h2);
        rd(CIPP_OFS_STATUS_B);
        finish_test();
    end
endmodule // tb_top
